// [verilog/twm_master.sv]
`default_nettype none
module twm_master
  import twm_pkg::*;
#(
  parameter int ADDR_W = 8,        // apb address width
  parameter int QTR    = QTR_CYC   // pclk cycles per quarter bit
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // interrupt
  output var  logic              irq,
  // bus clock line, open drain
  input  wire logic              scl_i,
  output var  logic              scl_o,
  output var  logic              scl_oe,
  // bus data line, open drain
  input  wire logic              sda_i,
  output var  logic              sda_o,
  output var  logic              sda_oe
);

  // =====================================================================
  // state
  // =====================================================================
  twm_state_e  state_q, state_d;    // engine state
  logic [1:0]  ph_q, ph_d;          // quarter-bit phase
  logic [15:0] cnt_q, cnt_d;        // quarter-bit timer
  logic [3:0]  bit_q, bit_d;        // bit index in packet
  logic [7:0]  data_q, data_d;      // serial_data_reg, doubles as shifter
  logic        flag_q, flag_d;      // completion flag
  logic        acken_q, acken_d;    // ack enable for received bytes
  logic        sta_q, sta_d;        // start request
  logic        sto_q, sto_d;        // stop request
  logic        wc_q, wc_d;          // write_collision_bit
  logic        en_q, en_d;          // interface enable
  logic        ie_q, ie_d;          // flag interrupt enable
  logic [1:0]  ps_q, ps_d;          // prescaler bits
  logic [7:0]  code_q, code_d;      // last status code
  logic        go_q, go_d;          // software released the flag
  logic        own_q, own_d;        // we hold the bus
  logic        addr_q, addr_d;      // next packet is an address
  logic        rx_q, rx_d;          // master receive mode
  logic        ack_q, ack_d;        // acknowledge of current packet
  logic        scl_oe_q, scl_oe_d;  // pull clock low
  logic        sda_oe_q, sda_oe_d;  // pull data low
  logic [IRQ_W-1:0] ist_q, ist_d;   // sticky events
  logic [IRQ_W-1:0] ien_q, ien_d;   // event enables
  logic        irq_q, irq_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;

  // =====================================================================
  // pin synchronisers and bus decode
  // =====================================================================
  logic scl_s;  // clock line, synchronised
  logic sda_s;  // data line, synchronised

  twm_sync #(.WIDTH(2)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({scl_i, sda_i}),
    .q     ({scl_s, sda_s})
  );

  logic       setup;    // apb setup cycle
  logic       wr;       // write takes effect now
  logic [7:0] offs;     // low address bits
  logic       mapped;   // address hits a register
  logic [15:0] limit;   // scaled quarter length
  logic       tick;     // quarter timer at end
  logic       adv;      // phase may advance
  logic       tx;       // this packet goes out on the data line

  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite && pready_q;
  assign offs   = 8'(paddr);
  assign mapped = (offs == OFS_CTRL) || (offs == OFS_STATUS) || (offs == OFS_DATA) ||
                  (offs == OFS_IST) || (offs == OFS_ICLR) || (offs == OFS_IEN);
  // prescaler stretches each quarter by a power of four
  assign limit  = 16'(QTR) << {ps_q, 1'b0};
  assign tick   = (cnt_q == limit - 16'h0001);
  // a slave holding the clock low stalls the high phase
  assign adv    = tick && !((ph_q == 2'd2) && !scl_s);
  assign tx     = addr_q || !rx_q;

  // =====================================================================
  // next state for registers and engine
  // =====================================================================
  always_comb begin
    logic             set_flag;   // hardware sets the flag this cycle
    logic [IRQ_W-1:0] ev;         // events this cycle
    set_flag  = 1'b0;
    ev        = '0;
    state_d   = state_q;
    ph_d      = ph_q;
    cnt_d     = cnt_q;
    bit_d     = bit_q;
    data_d    = data_q;
    flag_d    = flag_q;
    acken_d   = acken_q;
    sta_d     = sta_q;
    sto_d     = sto_q;
    wc_d      = wc_q;
    en_d      = en_q;
    ie_d      = ie_q;
    ps_d      = ps_q;
    code_d    = code_q;
    go_d      = go_q;
    own_d     = own_q;
    addr_d    = addr_q;
    rx_d      = rx_q;
    ack_d     = ack_q;
    scl_oe_d  = scl_oe_q;
    sda_oe_d  = sda_oe_q;
    ien_d     = ien_q;
    prdata_d  = prdata_q;
    // answer in the cycle after setup, no wait states
    pready_d  = setup;
    pslverr_d = setup && !mapped;

    // register writes
    if (wr && offs == OFS_CTRL) begin
      acken_d = pwdata[CB_ACKEN];
      sta_d   = pwdata[CB_STA];
      sto_d   = pwdata[CB_STO];
      en_d    = pwdata[CB_EN];
      ie_d    = pwdata[CB_IE];
      if (pwdata[CB_FLAG]) begin
        flag_d = 1'b0;
        go_d   = pwdata[CB_EN];
      end
    end
    if (wr && offs == OFS_STATUS) begin
      ps_d = pwdata[PS_W-1:0];
    end
    if (wr && offs == OFS_DATA) begin
      if (flag_q) begin
        data_d = pwdata[7:0];
        wc_d   = 1'b0;
      end else begin
        wc_d        = 1'b1;
        ev[IB_COLL] = 1'b1;
      end
    end
    if (wr && offs == OFS_IEN) begin
      ien_d = pwdata[IRQ_W-1:0];
    end

    // quarter timer, idle outside active states
    if (state_q == ST_IDLE || state_q == ST_HOLD) begin
      cnt_d = '0;
      ph_d  = 2'd0;
    end else if (adv) begin
      cnt_d = '0;
      ph_d  = ph_q + 2'd1;
    end else if (!tick) begin
      cnt_d = cnt_q + 16'h0001;
    end

    // engine
    unique case (state_q)
      ST_IDLE: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
        own_d    = 1'b0;
        if (go_q && en_q && !flag_q) begin
          if (sta_q) begin
            // wait for a free bus before starting
            if (scl_s && sda_s) begin
              go_d    = 1'b0;
              state_d = ST_START;
            end
          end else begin
            // nothing to stop or send without the bus
            go_d  = 1'b0;
            sto_d = 1'b0;
          end
        end
      end
      ST_START: begin
        if (adv) begin
          unique case (ph_q)
            2'd0: sda_oe_d = 1'b0;
            2'd1: scl_oe_d = 1'b0;
            2'd2: sda_oe_d = 1'b1;  // data falls while clock high
            2'd3: begin
              scl_oe_d = 1'b1;
              code_d   = own_q ? CODE_RSTRT : CODE_START;
              own_d    = 1'b1;
              addr_d   = 1'b1;
              set_flag = 1'b1;
              state_d  = ST_HOLD;
            end
          endcase
        end
      end
      ST_BITS: begin
        if (adv) begin
          unique case (ph_q)
            2'd0: begin
              if (bit_q < ACK_INDEX) begin
                // msb first; address lsb is the direction bit
                sda_oe_d = tx && !data_q[7];
              end else begin
                // receiver pulls low to acknowledge
                sda_oe_d = !tx && acken_q;
              end
            end
            2'd1: scl_oe_d = 1'b0;
            2'd2: begin
              if (bit_q < ACK_INDEX) begin
                if (tx && !sda_oe_q && !sda_s) begin
                  // someone else pulled our released bit low
                  code_d   = CODE_ARB;
                  set_flag = 1'b1;
                  sda_oe_d = 1'b0;
                  scl_oe_d = 1'b0;
                  state_d  = ST_IDLE;
                end else begin
                  data_d = {data_q[6:0], sda_s};
                end
              end else begin
                ack_d = tx ? !sda_s : acken_q;
              end
            end
            2'd3: begin
              scl_oe_d = 1'b1;
              if (bit_q < ACK_INDEX) begin
                bit_d = bit_q + 4'h1;
              end else begin
                sda_oe_d = 1'b0;
                set_flag = 1'b1;
                state_d  = ST_HOLD;
                addr_d   = 1'b0;
                if (addr_q) begin
                  rx_d = data_q[0];
                  if (data_q[0]) begin
                    code_d = ack_q ? CODE_AR_AK : CODE_AR_NK;
                  end else begin
                    code_d = ack_q ? CODE_AW_AK : CODE_AW_NK;
                  end
                end else if (rx_q) begin
                  code_d = ack_q ? CODE_RX_AK : CODE_RX_NK;
                end else begin
                  code_d = ack_q ? CODE_DT_AK : CODE_DT_NK;
                end
              end
            end
          endcase
        end
      end
      ST_STOP: begin
        if (adv) begin
          unique case (ph_q)
            2'd0: sda_oe_d = 1'b1;
            2'd1: scl_oe_d = 1'b0;
            2'd2: sda_oe_d = 1'b0;  // data rises while clock high
            2'd3: begin
              sto_d   = 1'b0;
              own_d   = 1'b0;
              go_d    = sta_q;      // start follows if sta_q is set by the end of the stop
              state_d = ST_IDLE;
            end
          endcase
        end
      end
      ST_HOLD: begin
        scl_oe_d = 1'b1;
        if (!en_q) begin
          // disabling drops the bus at once
          scl_oe_d = 1'b0;
          sda_oe_d = 1'b0;
          go_d     = 1'b0;
          state_d  = ST_IDLE;
        end else if (go_q && !flag_q) begin
          go_d = 1'b0;
          if (sta_q) begin
            state_d = ST_START;
          end else if (sto_q) begin
            state_d = ST_STOP;
          end else begin
            bit_d   = 4'h0;
            state_d = ST_BITS;
          end
        end
      end
    endcase

    // hardware set wins over a software clear
    if (set_flag) begin
      flag_d       = 1'b1;
      ev[IB_DONE]  = 1'b1;
    end
    ist_d = ist_q;
    if (wr && offs == OFS_ICLR) begin
      ist_d = ist_q & ~pwdata[IRQ_W-1:0];
    end
    ist_d = ist_d | ev;
    irq_d = (|(ist_d & ien_d)) || (flag_d && ie_d);

    // read data is latched in setup and shown in access
    if (setup) begin
      unique case (offs)
        OFS_CTRL:   prdata_d = {24'h000000, flag_q, acken_q, sta_q, sto_q, wc_q, en_q, 1'b0, ie_q};
        // code reads as none while the flag is low
        OFS_STATUS: prdata_d = {24'h000000, ((flag_q ? code_q : CODE_NONE) & CODE_MASK) |
                                {{(8-PS_W){1'b0}}, ps_q}};
        OFS_DATA:   prdata_d = {24'h000000, data_q};
        OFS_IST:    prdata_d = {{(32-IRQ_W){1'b0}}, ist_q};
        OFS_IEN:    prdata_d = {{(32-IRQ_W){1'b0}}, ien_q};
        default:    prdata_d = 32'h00000000;  // clear register and unmapped
      endcase
    end
  end

  // =====================================================================
  // registers
  // =====================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_IDLE;
      ph_q      <= 2'd0;
      cnt_q     <= 16'h0000;
      bit_q     <= 4'h0;
      data_q    <= DATA_RST;
      flag_q    <= 1'b0;
      acken_q   <= 1'b0;
      sta_q     <= 1'b0;
      sto_q     <= 1'b0;
      wc_q      <= 1'b0;
      en_q      <= 1'b0;
      ie_q      <= 1'b0;
      ps_q      <= 2'd0;
      code_q    <= CODE_NONE;
      go_q      <= 1'b0;
      own_q     <= 1'b0;
      addr_q    <= 1'b0;
      rx_q      <= 1'b0;
      ack_q     <= 1'b0;
      scl_oe_q  <= 1'b0;
      sda_oe_q  <= 1'b0;
      ist_q     <= '0;
      ien_q     <= '0;
      irq_q     <= 1'b0;
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      ph_q      <= ph_d;
      cnt_q     <= cnt_d;
      bit_q     <= bit_d;
      data_q    <= data_d;
      flag_q    <= flag_d;
      acken_q   <= acken_d;
      sta_q     <= sta_d;
      sto_q     <= sto_d;
      wc_q      <= wc_d;
      en_q      <= en_d;
      ie_q      <= ie_d;
      ps_q      <= ps_d;
      code_q    <= code_d;
      go_q      <= go_d;
      own_q     <= own_d;
      addr_q    <= addr_d;
      rx_q      <= rx_d;
      ack_q     <= ack_d;
      scl_oe_q  <= scl_oe_d;
      sda_oe_q  <= sda_oe_d;
      ist_q     <= ist_d;
      ien_q     <= ien_d;
      irq_q     <= irq_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // =====================================================================
  // outputs; lines are only ever pulled low
  // =====================================================================
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;
  assign scl_o   = 1'b0;
  assign scl_oe  = scl_oe_q;
  assign sda_o   = 1'b0;
  assign sda_oe  = sda_oe_q;

endmodule : twm_master
`default_nettype wire

// [verilog/twm_pkg.sv]
`default_nettype none
// =====================================================================
// shared constants for the two-wire master
// =====================================================================
package twm_pkg;

  // =====================================================================
  // timing
  // =====================================================================
  localparam int unsigned CLK_PERIOD_NS = 25;     // pclk period
  localparam int unsigned SCL_PERIOD_NS = 10000;  // nominal bus bit period
  localparam int unsigned QTR_NS        = SCL_PERIOD_NS / 4;  // one quarter of a bit
  // least time, so round up to whole cycles
  localparam int unsigned QTR_CYC       = (QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // =====================================================================
  // apb register offsets (byte addresses)
  // =====================================================================
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // serial_control_reg
  localparam logic [7:0] OFS_STATUS = 8'h04;  // serial_status_reg
  localparam logic [7:0] OFS_DATA   = 8'h08;  // serial_data_reg
  localparam logic [7:0] OFS_IST    = 8'h0C;  // sticky event status, read only
  localparam logic [7:0] OFS_ICLR   = 8'h10;  // event clear, write only
  localparam logic [7:0] OFS_IEN    = 8'h14;  // event enable

  // =====================================================================
  // control register fields
  // =====================================================================
  localparam int CB_FLAG  = 7;  // completion flag, write one to clear
  localparam int CB_ACKEN = 6;  // acknowledge received bytes
  localparam int CB_STA   = 5;  // start request
  localparam int CB_STO   = 4;  // stop request
  localparam int CB_WC    = 3;  // write_collision_bit, read only
  localparam int CB_EN    = 2;  // interface enable
  localparam int CB_IE    = 0;  // completion flag drives irq

  // =====================================================================
  // status register fields and codes
  // =====================================================================
  localparam logic [7:0] CODE_MASK  = 8'hF8;  // code part of the status register
  localparam int         PS_W       = 2;      // prescaler bits at the bottom
  localparam logic [7:0] CODE_START = 8'h08;
  localparam logic [7:0] CODE_RSTRT = 8'h10;
  localparam logic [7:0] CODE_AW_AK = 8'h18;  // addr_acked_code
  localparam logic [7:0] CODE_AW_NK = 8'h20;
  localparam logic [7:0] CODE_DT_AK = 8'h28;  // data_acked_code
  localparam logic [7:0] CODE_DT_NK = 8'h30;
  localparam logic [7:0] CODE_ARB   = 8'h38;
  localparam logic [7:0] CODE_AR_AK = 8'h40;
  localparam logic [7:0] CODE_AR_NK = 8'h48;
  localparam logic [7:0] CODE_RX_AK = 8'h50;
  localparam logic [7:0] CODE_RX_NK = 8'h58;
  localparam logic [7:0] CODE_NONE  = 8'hF8;  // no relevant status

  // =====================================================================
  // event bits, packet shape, reset values
  // =====================================================================
  localparam int         IRQ_W     = 2;
  localparam int         IB_DONE   = 0;  // completion flag was set
  localparam int         IB_COLL   = 1;  // data write collided
  localparam logic [3:0] ACK_INDEX = 4'h8;  // eight data bits, then acknowledge
  localparam logic [7:0] DATA_RST  = 8'hFF;

  // engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BITS,
    ST_STOP,
    ST_HOLD
  } twm_state_e;

endpackage : twm_pkg
`default_nettype wire

// [verilog/twm_sync.sv]
`default_nettype none
// =====================================================================
// two flip-flop synchroniser for bus pins
// =====================================================================
module twm_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;  // first stage, read by second stage only

  // =====================================================================
  // both stages; released lines idle high
  // =====================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : twm_sync
`default_nettype wire

// [verification/twm_asserts.sv]
`default_nettype none
// =====================================================================
// port checks for the two-wire master
// =====================================================================
module twm_asserts
  import twm_pkg::*;
#(
  parameter int ADDR_W = 8,  // apb address width
  parameter int QTR    = 2   // cycles per quarter bit
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr,
  // bus lines
  input  wire logic              scl_o,
  input  wire logic              scl_oe,
  input  wire logic              sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] low_q;  // consecutive cycles scl pulled low, cleared by a control write
  logic [15:0] low_d;
  logic        setup;  // apb setup cycle
  logic        ctl_wr; // control write lands
  assign setup  = psel && !penable;
  assign ctl_wr = psel && penable && pwrite && paddr[7:0] == OFS_CTRL;
  // a low phase past two bits is the hold; limited to prescaler zero
  always_comb begin
    low_d = (scl_oe && !ctl_wr) ? low_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_q <= 16'h0000;
    else low_q <= low_d;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SCL_OD: assert property (scl_o == 1'b0)
    else $error("scl driven high");
  AST_SDA_OD: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  AST_RDY_NEXT: assert property (setup |=> pready)
    else $error("no ready after setup");
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_RDY_ACC: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_ERR_MAP: assert property (setup && paddr[7:0] == 8'h20 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_ERR_OK: assert property (setup && paddr[7:0] <= OFS_IEN && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  AST_STAT_FMT: assert property (setup && !pwrite && paddr[7:0] == OFS_STATUS |=> prdata[31:8] == 24'h0 && !prdata[2])
    else $error("status layout wrong");
  AST_ICLR_RD: assert property (setup && !pwrite && paddr[7:0] == OFS_ICLR |=> prdata == 32'h0)
    else $error("clear register reads nonzero");
  AST_HOLD: assert property (low_q > 8 * QTR && !ctl_wr |=> scl_oe)
    else $error("scl released without software");
endmodule : twm_asserts

bind twm_master twm_asserts #(.ADDR_W(ADDR_W), .QTR(QTR)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o));
`default_nettype wire

// [verification/twm_slave_model.sv]
`default_nettype none
// =====================================================================
// behavioural bus slave: acks or refuses, may stretch
// =====================================================================
module twm_slave_model (
  // resolved lines
  input  wire logic       scl,
  input  wire logic       sda,
  // behaviour
  input  wire logic       nack_i,
  input  wire logic       slow_i,
  // pulls and observations
  output var  logic       sda_pull,
  output var  logic       scl_pull,
  output var  logic [7:0] rx_byte,
  output var  int         n_start,
  output var  int         n_stop
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] bit_q;  // position in packet
  logic [7:0] sh_q;   // incoming bits
  initial begin
    {sda_pull, scl_pull, bit_q, sh_q, rx_byte} = '0;
    n_start = 0;
    n_stop  = 0;
  end
  // sda edges with scl high frame the transfer
  always @(negedge sda) if (scl) begin
    n_start++;
    bit_q = 4'h0;
  end
  // lines settling out of reset at time zero are no stop
  always @(posedge sda) if (scl && $time > 0) n_stop++;
  // msb first, eight data bits then the ack slot
  always @(posedge scl) begin
    if (bit_q < 4'h8) sh_q = {sh_q[6:0], sda};
    if (bit_q == 4'h7) rx_byte = sh_q;
    bit_q++;
  end
  // low is ack, released line reads as nack
  always @(negedge scl) begin
    sda_pull = (bit_q == 4'h8) && !nack_i;
    if (bit_q == 4'h9) bit_q = 4'h0;
    if (slow_i) begin
      scl_pull = 1'b1;
      #300 scl_pull = 1'b0;
    end
  end
endmodule : twm_slave_model
`default_nettype wire

// [verification/twm_master_tb.sv]
`default_nettype none
module twm_master_tb;
  import twm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int QTR = 2;  // 200 ns bus bit
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, rx_byte;
  logic [31:0] pwdata, prdata, rd;
  logic        scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull, nack, slow, err;
  int          n_fail, checks_done, n_start, n_stop;
  // pull-ups on both lines
  wire logic   scl = !(scl_oe || scl_pull);
  wire logic   sda = !(sda_oe || sda_pull);
  twm_master #(.ADDR_W(8), .QTR(QTR)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  twm_slave_model slv_u (.scl(scl), .sda(sda), .nack_i(nack), .slow_i(slow), .sda_pull(sda_pull),
    .scl_pull(scl_pull), .rx_byte(rx_byte), .n_start(n_start), .n_stop(n_stop));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, then an idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
    if (n >= 16) begin
      n_fail++;
      finish_test();
    end
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  // poll the completion flag, bounded
  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_CTRL, 32'h0);
      n++;
    end while (rd[CB_FLAG] !== 1'b1 && n < 600);
    if (n >= 600) begin
      n_fail++;
      finish_test();
    end
  endtask : wait_flag
  // load data unless starting, release, await code
  task automatic xfer(input logic [7:0] d, input logic [7:0] c, input logic [7:0] code);
    if (!c[CB_STA]) apb(1'b1, OFS_DATA, {24'h0, d});
    apb(1'b1, OFS_CTRL, {24'h0, c});
    wait_flag();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'hF8, {24'h0, code});
  endtask : xfer
  initial begin
    {presetn, psel, penable, pwrite, nack, slow} = '0;
    {paddr, pwdata, n_fail, checks_done} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_STATUS, 32'hF8);
    rdc(OFS_DATA, 32'hFF);
    rdc(OFS_IST, 32'h0);
    rdc(OFS_IEN, 32'h0);
    apb(1'b1, OFS_STATUS, 32'h3);
    rdc(OFS_STATUS, 32'hFB);
    apb(1'b1, OFS_STATUS, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("done: registers");
    // collision while idle, masked then enabled
    apb(1'b1, OFS_DATA, 32'h55);
    rdc(OFS_IST, 32'h2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_IEN, 32'h2);
    chk({31'h0, irq}, 32'h1);
    rdc(OFS_CTRL, 32'h08);
    rdc(OFS_DATA, 32'hFF);
    apb(1'b1, OFS_ICLR, 32'h2);
    chk({31'h0, irq}, 32'h0);
    $display("done: collision");
    // master write: start, address, data acked, data refused
    xfer(8'h00, 8'hA5, CODE_START);
    chk({31'h0, irq}, 32'h1);
    repeat (60) @(posedge pclk);
    chk({31'h0, scl_oe}, 32'h1);
    xfer(8'hA0, 8'h85, CODE_AW_AK);
    chk(rx_byte, 8'hA0);
    rdc(OFS_CTRL, 32'h85);
    xfer(8'h3C, 8'h85, CODE_DT_AK);
    chk(rx_byte, 8'h3C);
    nack <= 1'b1;
    slow <= 1'b1;
    xfer(8'hC3, 8'h85, CODE_DT_NK);
    chk(rx_byte, 8'hC3);
    nack <= 1'b0;
    slow <= 1'b0;
    // control write without the flag bit keeps holding
    apb(1'b1, OFS_CTRL, 32'h05);
    repeat (80) @(posedge pclk);
    rdc(OFS_CTRL, 32'h85);
    $display("done: write");
    // repeated start into a read address
    xfer(8'h00, 8'hA5, CODE_RSTRT);
    chk(n_start, 2);
    xfer(8'hA1, 8'h85, CODE_AR_AK);
    chk(rx_byte, 8'hA1);
    // receive one byte from a released line and acknowledge it
    xfer(8'h00, 8'hC5, CODE_RX_AK);
    rdc(OFS_DATA, 32'hFF);
    apb(1'b1, OFS_CTRL, 32'h94);
    repeat (100) @(posedge pclk);
    chk(n_stop, 1);
    rdc(OFS_CTRL, 32'h04);
    rdc(OFS_STATUS, 32'hF8);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    rdc(OFS_IST, 32'h1);
    $display("done: read and stop");
    finish_test();
  end
endmodule : twm_master_tb
`default_nettype wire
